// >>> common/tmc_pkg.sv
// Package: addresses, fields and encodings of the three timer/counters
//
// Overview of operation
// - Timer 2 overflow sets its overflow flag, never in baud mode.
// - Enabled timer2 edge input fall causing capture/reload sets edge flag.
// - Receive baud select picks timer 2 or timer 1 overflow strobes.
// - Transmit baud select picks timer 2 or timer 1 overflow strobes.
// - Edge enable allows edge capture/reload unless timer 2 clocks serial.
// - Timer 2 counts only while its run bit is one.
// - Count select picks timer2 count pin events or core clock.
// - Capture select picks capture or reload; baud mode forces reload.
// - Timers 0 and 1 are two byte registers, combined per mode.
// - Mode 0 counts 13 bits: high byte plus low five bits.
// - Wrap from all ones to zero sets the timer overflow flag.
// - Count enabled by run bit and gate off or interrupt pin high.
// - No prescaler; timer function advances once per core cycle.
// - Setting a run bit leaves the count registers untouched.
// - Mode 1 is mode 0 using all sixteen bits.
// - Mode 2 low byte counts, reloads from unchanged high byte.
// - Timer 1 in mode 3 holds its count.
// - Timer 0 mode 3 low byte uses timer 0 controls and flag.
// - Timer 0 mode 3 high byte counts cycles on timer 1 run/flag.
// - Then timer 1 runs outside its mode 3, baud use, no flag.
// - Mode codes: 00 13-bit, 01 16-bit, 10 reload, 11 split.
// - Timer 0/1 overflow flags clear when the core vectors.
// - Timer 2 mode: baud, else capture or reload; run zero is off.
// - Capture copies timer 2 low/high bytes to reload low/high.
package tmc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_A_CTRL01 = 8'h88;
  localparam logic [7:0] TMC_A_MODE01 = 8'h89;
  localparam logic [7:0] TMC_A_TL0    = 8'h8A;
  localparam logic [7:0] TMC_A_TL1    = 8'h8B;
  localparam logic [7:0] TMC_A_TH0    = 8'h8C;
  localparam logic [7:0] TMC_A_TH1    = 8'h8D;
  localparam logic [7:0] TMC_A_CTRL2  = 8'hC8;
  localparam logic [7:0] TMC_A_RLD2L  = 8'hCA;
  localparam logic [7:0] TMC_A_RLD2H  = 8'hCB;
  localparam logic [7:0] TMC_A_TL2    = 8'hCC;
  localparam logic [7:0] TMC_A_TH2    = 8'hCD;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TMC_B_TF1 = 7;
  localparam int TMC_B_TR1 = 6;
  localparam int TMC_B_TF0 = 5;
  localparam int TMC_B_TR0 = 4;
  localparam int TMC_P13   = 5;  // prescaler bits in mode 0
  localparam logic [7:0] TMC_RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TMC_M13   = 2'h0;
  localparam logic [1:0] TMC_M16   = 2'h1;
  localparam logic [1:0] TMC_M8R   = 2'h2;
  localparam logic [1:0] TMC_MSPLT = 2'h3;

  typedef enum logic [1:0] {
    TMC_T2_OFF  = 2'b00,
    TMC_T2_AUTO = 2'b01,
    TMC_T2_CAPT = 2'b10,
    TMC_T2_BAUD = 2'b11
  } tmc_t2_mode_t;

  // One nibble of the timer 0/1 mode register
  typedef struct packed {
    logic       gate;
    logic       ct;
    logic [1:0] mode;
  } tmc_timer01_mode_reg_t;

  // Timer 2 control register, bit 7 first
  typedef struct packed {
    logic tf2;
    logic timer2_edge_flag;
    logic rclk;
    logic tx_baud_from_timer2;
    logic timer2_edge_enable;
    logic tr2;
    logic ct2;
    logic timer2_capture_select;
  } tmc_timer2_control_t;

  // External pins, all asynchronous to the core clock
  typedef struct packed {
    logic irq1;
    logic irq0;
    logic timer2_edge_input;
    logic t2;
    logic t1;
    logic t0;
  } tmc_pins_t;

  localparam int TMC_NPINS = 6;

endpackage : tmc_pkg

// >>> core/tmc_pin_sync.sv
// Two-stage synchroniser with falling-edge strobe for one pin
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_sync (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Pin and results
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;
  logic meta_d;
  logic sync_d;
  logic last_d;

  // Only sync_q and later stages feed logic
  always_comb begin
    meta_d = i_pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign o_level = sync_q;
  assign o_fall  = last_q & ~sync_q;

endmodule : tmc_pin_sync
`default_nettype wire

// >>> core/tmc_timers.sv
// Timer/counters 0, 1 and 2 with their special function registers
`timescale 1ns/1ps
`default_nettype none
module tmc_timers
  import tmc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Special function register port
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  // Interrupt vector acknowledges from the core
  input  wire logic       i_timer0_vector,
  input  wire logic       i_timer1_vector,
  // External pins
  input  wire logic       i_ext_irq0_pin,
  input  wire logic       i_ext_irq1_pin,
  input  wire logic       i_timer0_count_input,
  input  wire logic       i_timer1_count_input,
  input  wire logic       i_timer2_count_input,
  input  wire logic       i_timer2_edge_input,
  // Interrupt requests and serial baud strobes
  output logic            o_timer0_irq,
  output logic            o_timer1_irq,
  output logic            o_timer2_irq,
  output logic            o_rx_baud_tick,
  output logic            o_tx_baud_tick
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Release is synchronised so all flops leave reset on one edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  tmc_pins_t pin_raw;
  tmc_pins_t pin_lvl;
  tmc_pins_t pin_fall;

  assign pin_raw = '{irq1: i_ext_irq1_pin, irq0: i_ext_irq0_pin,
                     timer2_edge_input: i_timer2_edge_input,
                     t2: i_timer2_count_input,
                     t1: i_timer1_count_input,
                     t0: i_timer0_count_input};

  genvar gi;
  generate
    for (gi = 0; gi < TMC_NPINS; gi++) begin : g_sync
      tmc_pin_sync u_sync (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_pin   (pin_raw[gi]),
        .o_level (pin_lvl[gi]),
        .o_fall  (pin_fall[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // One count step of a timer 0/1 pair: {overflow, high, low}
  function automatic logic [16:0] tmc_step(
    input logic [1:0] m,
    input logic [7:0] th,
    input logic [7:0] tl
  );
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    logic [16:0] r;
    begin
      c13 = {1'b0, th, tl[TMC_P13-1:0]} + 14'h1;
      c16 = {1'b0, th, tl} + 17'h1;
      c8  = {1'b0, tl} + 9'h1;
      case (m)
        // Upper low-byte bits are left alone, they carry no count
        TMC_M13: r = {c13[13], c13[12:TMC_P13], tl[7:TMC_P13],
                      c13[TMC_P13-1:0]};
        TMC_M16: r = c16;
        TMC_M8R: r = {c8[8], th, c8[8] ? th : c8[7:0]};
        default: r = {c8[8], th, c8[7:0]};
      endcase
      return r;
    end
  endfunction : tmc_step

  // Write strobe decode, used for every register
  function automatic logic tmc_hit(input logic [7:0] a);
    return i_sfr_wr && (i_sfr_addr == a);
  endfunction : tmc_hit

  // ----------------------------------------------------------------
  // Timer 0 and timer 1
  // ----------------------------------------------------------------
  logic [7:0] tl0_q, tl0_d, th0_q, th0_d;
  logic [7:0] tl1_q, tl1_d, th1_q, th1_d;
  tmc_timer01_mode_reg_t  md0_q, md0_d, md1_q, md1_d;
  logic       tr0_q, tr0_d, tr1_q, tr1_d;
  logic       tf0_q, tf0_d, tf1_q, tf1_d;
  logic       t1ovf_q, t1ovf_d;
  logic       en0, en1, enh0, split0;
  logic [16:0] st0, st1;
  logic [8:0]  h0;
  logic        set_tf0, set_tf1;

  always_comb begin
    split0 = (md0_q.mode == TMC_MSPLT);
    // Gate pin only holds the count, run bit is the master
    en0 = tr0_q && (!md0_q.gate || pin_lvl.irq0)
          && (md0_q.ct ? pin_fall.t0 : 1'b1);
    // Timer 1 runs free of its run bit while timer 0 is split
    en1 = (split0 ? 1'b1 : tr1_q)
          && (!md1_q.gate || pin_lvl.irq1)
          && (md1_q.ct ? pin_fall.t1 : 1'b1)
          && (md1_q.mode != TMC_MSPLT);
    enh0 = split0 && tr1_q;
    st0 = tmc_step(md0_q.mode, th0_q, tl0_q);
    st1 = tmc_step(md1_q.mode, th1_q, tl1_q);
    h0  = {1'b0, th0_q} + 9'h1;
    tl0_d = tl0_q;
    th0_d = th0_q;
    tl1_d = tl1_q;
    th1_d = th1_q;
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    t1ovf_d = 1'b0;
    // Counting; the run bit never touches the count bytes
    if (en0) begin
      tl0_d = st0[7:0];
      if (!split0) begin
        th0_d = st0[15:8];
      end
      set_tf0 = st0[16];
    end
    if (enh0) begin
      th0_d   = h0[7:0];
      set_tf1 = h0[8];
    end
    if (en1) begin
      tl1_d   = st1[7:0];
      th1_d   = st1[15:8];
      t1ovf_d = st1[16];
      if (!split0) begin
        set_tf1 = st1[16];
      end
    end
    // Software writes win over a count in the same cycle
    if (tmc_hit(TMC_A_TL0)) tl0_d = i_sfr_wdata;
    if (tmc_hit(TMC_A_TH0)) th0_d = i_sfr_wdata;
    if (tmc_hit(TMC_A_TL1)) tl1_d = i_sfr_wdata;
    if (tmc_hit(TMC_A_TH1)) th1_d = i_sfr_wdata;
    md0_d = md0_q;
    md1_d = md1_q;
    if (tmc_hit(TMC_A_MODE01)) begin
      md1_d = i_sfr_wdata[7:4];
      md0_d = i_sfr_wdata[3:0];
    end
    tr0_d = tr0_q;
    tr1_d = tr1_q;
    tf0_d = tf0_q & ~i_timer0_vector;
    tf1_d = tf1_q & ~i_timer1_vector;
    if (tmc_hit(TMC_A_CTRL01)) begin
      tr0_d = i_sfr_wdata[TMC_B_TR0];
      tr1_d = i_sfr_wdata[TMC_B_TR1];
      tf0_d = i_sfr_wdata[TMC_B_TF0];
      tf1_d = i_sfr_wdata[TMC_B_TF1];
    end
    // A new overflow outranks any clear in the same cycle
    tf0_d = tf0_d | set_tf0;
    tf1_d = tf1_d | set_tf1;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tl0_q   <= TMC_RST_BYTE;
      th0_q   <= TMC_RST_BYTE;
      tl1_q   <= TMC_RST_BYTE;
      th1_q   <= TMC_RST_BYTE;
      md0_q   <= '0;
      md1_q   <= '0;
      tr0_q   <= 1'b0;
      tr1_q   <= 1'b0;
      tf0_q   <= 1'b0;
      tf1_q   <= 1'b0;
      t1ovf_q <= 1'b0;
    end else begin
      tl0_q   <= tl0_d;
      th0_q   <= th0_d;
      tl1_q   <= tl1_d;
      th1_q   <= th1_d;
      md0_q   <= md0_d;
      md1_q   <= md1_d;
      tr0_q   <= tr0_d;
      tr1_q   <= tr1_d;
      tf0_q   <= tf0_d;
      tf1_q   <= tf1_d;
      t1ovf_q <= t1ovf_d;
    end
  end

  // ----------------------------------------------------------------
  // Timer 2
  // ----------------------------------------------------------------
  tmc_timer2_control_t   c2_q, c2_d;
  logic [7:0]   tl2_q, tl2_d, th2_q, th2_d;
  logic [7:0]   rl2_q, rl2_d, rh2_q, rh2_d;
  logic         rxt_q, rxt_d, txt_q, txt_d;
  tmc_t2_mode_t t2_mode;
  logic         baud2, tick2, edge2, set_tf2, ovf2;
  logic [16:0]  c2n;

  always_comb begin
    baud2 = c2_q.rclk | c2_q.tx_baud_from_timer2;
    if (!c2_q.tr2) begin
      t2_mode = TMC_T2_OFF;
    end else if (baud2) begin
      t2_mode = TMC_T2_BAUD;
    end else if (c2_q.timer2_capture_select) begin
      t2_mode = TMC_T2_CAPT;
    end else begin
      t2_mode = TMC_T2_AUTO;
    end
    tick2 = c2_q.ct2 ? pin_fall.t2 : 1'b1;
    edge2 = c2_q.timer2_edge_enable & pin_fall.timer2_edge_input;
    c2n   = {1'b0, th2_q, tl2_q} + 17'h1;
    ovf2  = 1'b0;
    tl2_d = tl2_q;
    th2_d = th2_q;
    rl2_d = rl2_q;
    rh2_d = rh2_q;
    set_tf2 = 1'b0;
    case (t2_mode)
      TMC_T2_AUTO, TMC_T2_BAUD: begin
        if (tick2) begin
          ovf2 = c2n[16];
          // Reload replaces the wrap when the count overflows
          {th2_d, tl2_d} = ovf2 ? {rh2_q, rl2_q} : c2n[15:0];
        end
      end
      TMC_T2_CAPT: begin
        if (tick2) begin
          ovf2 = c2n[16];
          {th2_d, tl2_d} = c2n[15:0];
        end
      end
      default: begin
        ovf2 = 1'b0;
      end
    endcase
    set_tf2 = ovf2 & ~baud2;
    // Edges act even while stopped; baud use blocks the action
    if (edge2 && !baud2) begin
      if (c2_q.timer2_capture_select) begin
        rl2_d = tl2_q;
        rh2_d = th2_q;
      end else begin
        {th2_d, tl2_d} = {rh2_q, rl2_q};
      end
    end
    // Baud strobes last one cycle per overflow
    rxt_d = c2_q.rclk ? (ovf2 & baud2) : t1ovf_q;
    txt_d = c2_q.tx_baud_from_timer2 ? (ovf2 & baud2) : t1ovf_q;
    if (tmc_hit(TMC_A_TL2)) tl2_d = i_sfr_wdata;
    if (tmc_hit(TMC_A_TH2)) th2_d = i_sfr_wdata;
    if (tmc_hit(TMC_A_RLD2L)) rl2_d = i_sfr_wdata;
    if (tmc_hit(TMC_A_RLD2H)) rh2_d = i_sfr_wdata;
    c2_d = c2_q;
    if (tmc_hit(TMC_A_CTRL2)) c2_d = tmc_timer2_control_t'(i_sfr_wdata);
    // Hardware sets outrank a software clear
    c2_d.tf2  = c2_d.tf2 | set_tf2;
    c2_d.timer2_edge_flag = c2_d.timer2_edge_flag | edge2;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      c2_q  <= '0;
      tl2_q <= TMC_RST_BYTE;
      th2_q <= TMC_RST_BYTE;
      rl2_q <= TMC_RST_BYTE;
      rh2_q <= TMC_RST_BYTE;
      rxt_q <= 1'b0;
      txt_q <= 1'b0;
    end else begin
      c2_q  <= c2_d;
      tl2_q <= tl2_d;
      th2_q <= th2_d;
      rl2_q <= rl2_d;
      rh2_q <= rh2_d;
      rxt_q <= rxt_d;
      txt_q <= txt_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data and request outputs
  // ----------------------------------------------------------------
  logic [7:0] rd_q, rd_d;
  logic       irq0_q, irq1_q, irq2_q;

  // Read data trails the address by one cycle; low control bits are
  // owned by the external interrupt logic and read as zero here
  always_comb begin
    case (i_sfr_addr)
      TMC_A_CTRL01: rd_d = {tf1_q, tr1_q, tf0_q, tr0_q, 4'h0};
      TMC_A_MODE01: rd_d = {md1_q, md0_q};
      TMC_A_TL0:    rd_d = tl0_q;
      TMC_A_TL1:    rd_d = tl1_q;
      TMC_A_TH0:    rd_d = th0_q;
      TMC_A_TH1:    rd_d = th1_q;
      TMC_A_CTRL2:  rd_d = c2_q;
      TMC_A_RLD2L:  rd_d = rl2_q;
      TMC_A_RLD2H:  rd_d = rh2_q;
      TMC_A_TL2:    rd_d = tl2_q;
      TMC_A_TH2:    rd_d = th2_q;
      default:      rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q   <= 8'h00;
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
    end else begin
      rd_q   <= rd_d;
      irq0_q <= tf0_d;
      irq1_q <= tf1_d;
      irq2_q <= c2_d.tf2 | c2_d.timer2_edge_flag;
    end
  end

  assign o_sfr_rdata    = rd_q;
  assign o_timer0_irq   = irq0_q;
  assign o_timer1_irq   = irq1_q;
  assign o_timer2_irq   = irq2_q;
  assign o_rx_baud_tick = rxt_q;
  assign o_tx_baud_tick = txt_q;

endmodule : tmc_timers
`default_nettype wire

// >>> verif/tmc_timers_properties.sv
// Port checker for the timer/counter block and its bind
`timescale 1ns/1ps
`default_nettype none
module tmc_timers_chk (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  // Register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  // Flags and strobes
  input wire logic       i_timer0_vector,
  input wire logic       o_timer0_irq,
  input wire logic       o_timer2_irq,
  input wire logic       o_rx_baud_tick,
  input wire logic       o_tx_baud_tick
);
  logic [7:0] c01_q, md_q, c2_q;
  logic       rxi_q, txi_q, t1_idle, rxi, txi, wr88, wrc8;
  logic       rxi_qq, txi_qq;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Write decodes for the control bytes
  assign wr88 = i_sfr_wr && i_sfr_addr == 8'h88;
  assign wrc8 = i_sfr_wr && i_sfr_addr == 8'hC8;
  // Timer 1 cannot wrap: held in mode 3, or stopped and not split off
  assign t1_idle = md_q[5:4] == 2'h3 || (!c01_q[6] && md_q[1:0] != 2'h3);
  assign rxi = c2_q[5] ? !c2_q[2] : t1_idle;
  assign txi = c2_q[4] ? !c2_q[2] : t1_idle;

  // Shadow copies; timer 1 ticks trail its wrap by two cycles
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      c01_q <= 8'h00;
      md_q  <= 8'h00;
      c2_q  <= 8'h00;
      rxi_q <= 1'b0;
      txi_q <= 1'b0;
      rxi_qq <= 1'b0;
      txi_qq <= 1'b0;
    end else begin
      c01_q <= wr88 ? i_sfr_wdata : c01_q;
      md_q  <= (i_sfr_wr && i_sfr_addr == 8'h89) ? i_sfr_wdata : md_q;
      c2_q  <= wrc8 ? i_sfr_wdata : c2_q;
      rxi_q <= rxi;
      txi_q <= txi;
      rxi_qq <= rxi_q;
      txi_qq <= txi_q;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_rld_wr;
    i_sfr_wr && i_sfr_addr == 8'hCA && !c2_q[3];
  endsequence
  sequence s_rld_rd;
    !i_sfr_wr && i_sfr_addr == 8'hCA && !c2_q[3];
  endsequence
  property p_rld_back;
    s_rld_wr ##1 s_rld_rd |=> o_sfr_rdata == $past(i_sfr_wdata, 2);
  endproperty
  a_rld_back: assert property (p_rld_back)
    else $error("reload byte lost its written value");
  property p_unmapped;
    i_sfr_addr == 8'h90 |=> o_sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_flag0_set;
    wr88 && i_sfr_wdata[5] && !i_timer0_vector |=> o_timer0_irq;
  endproperty
  a_flag0_set: assert property (p_flag0_set)
    else $error("timer 0 flag write lost");
  property p_vec0_clr;
    i_timer0_vector && !c01_q[4] && !wr88 |=> !o_timer0_irq;
  endproperty
  a_vec0_clr: assert property (p_vec0_clr)
    else $error("vector left timer 0 flag set");
  property p_t2_baud;
    (c2_q[5] || c2_q[4]) && !c2_q[3] && !wrc8 && !o_timer2_irq
      |=> !o_timer2_irq;
  endproperty
  a_t2_baud: assert property (p_t2_baud)
    else $error("timer 2 flag set in baud use");
  property p_t2_stop;
    !c2_q[2] && !c2_q[3] && !wrc8 && !o_timer2_irq |=> !o_timer2_irq;
  endproperty
  a_t2_stop: assert property (p_t2_stop)
    else $error("stopped timer 2 raised a flag");
  property p_rx_src;
    rxi && rxi_q && rxi_qq |-> !o_rx_baud_tick;
  endproperty
  a_rx_src: assert property (p_rx_src)
    else $error("receive tick from an idle source");
  property p_tx_src;
    txi && txi_q && txi_qq |-> !o_tx_baud_tick;
  endproperty
  a_tx_src: assert property (p_tx_src)
    else $error("transmit tick from an idle source");
endmodule : tmc_timers_chk

bind tmc_timers tmc_timers_chk u_chk (
  .i_clk, .i_reset_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .o_sfr_rdata,
  .i_timer0_vector, .o_timer0_irq, .o_timer2_irq, .o_rx_baud_tick,
  .o_tx_baud_tick
);
`default_nettype wire

// >>> verif/mcu_timer_counters_0_1_2_tb.sv
// Self-checking bench for the timer/counter block
`timescale 1ns/1ps
`default_nettype none
module mcu_timer_counters_0_1_2_tb;
  import tmc_pkg::*;
  logic       i_clk, i_reset_n, wr, v0, v1, g0, g1, p0, p1, p2, ex;
  logic [7:0] a, d, rd, v;
  logic       q0, q1, q2, rxt, txt;
  int         fail_count, n_tests, cyc, nr, nt;
  // Rows of address, write data and expected read back
  logic [23:0] rows [12] = '{24'h8AA5A5, 24'h8B5A5A, 24'h8C3C3C,
    24'h8DC3C3, 24'hCA1212, 24'hCB3434, 24'hCC5656, 24'hCD7878,
    24'h895A5A, 24'hC80303, 24'h880F00, 24'h90FF00};

  tmc_timers u_dut (
    .i_clk, .i_reset_n, .i_sfr_addr(a), .i_sfr_wr(wr), .i_sfr_wdata(d),
    .o_sfr_rdata(rd), .i_timer0_vector(v0), .i_timer1_vector(v1),
    .i_ext_irq0_pin(g0), .i_ext_irq1_pin(g1), .i_timer0_count_input(p0),
    .i_timer1_count_input(p1), .i_timer2_count_input(p2),
    .i_timer2_edge_input(ex), .o_timer0_irq(q0), .o_timer1_irq(q1),
    .o_timer2_irq(q2), .o_rx_baud_tick(rxt), .o_tx_baud_tick(txt)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [15:0] ad);
    @(posedge i_clk);
    a  <= ad[15:8];
    d  <= ad[7:0];
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask : w
  task automatic ws(input logic [15:0] s[$]);
    foreach (s[i]) w(s[i]);
  endtask : ws
  // Read data is registered, so it lands one edge after the address
  task automatic r(input logic [7:0] ad);
    @(posedge i_clk);
    a <= ad;
    @(posedge i_clk);
    #1 v = rd;
  endtask : r
  task automatic t(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : t
  task automatic report_and_stop;
    $display("Compared %0d, mismatched %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Clock and hang guard
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Main sequence
  initial begin
    {i_reset_n, wr, v0, v1, g0, g1} = 6'h00;
    {p0, p1, p2, ex} = 4'hF;
    {a, d} = 16'h0000;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    foreach (rows[i]) begin
      r(rows[i][23:16]);
      chk(v, 8'h00);
    end
    foreach (rows[i]) begin
      w(rows[i][23:8]);
      r(rows[i][23:16]);
      chk(v, rows[i][7:0]);
    end
    // Sixteen-bit wrap two cycles after start, then vector clear
    ws('{16'h8901, 16'h8AFE, 16'h8CFF, 16'h8810});
    t(1);
    chk(q0, 1'b0);
    t(1);
    chk(q0, 1'b1);
    @(posedge i_clk);
    v0 <= 1'b1;
    @(posedge i_clk);
    v0 <= 1'b0;
    #1 chk(q0, 1'b0);
    // Thirteen-bit wrap from all ones
    ws('{16'h8800, 16'h8900, 16'h8CFF, 16'h8AFF, 16'h8810});
    t(1);
    chk(q0, 1'b1);
    r(8'h8C);
    chk(v, 8'h00);
    // Eight-bit reload keeps the high byte
    ws('{16'h8800, 16'h8902, 16'h8CF0, 16'h8AFE, 16'h8810});
    t(1);
    chk(q0, 1'b0);
    t(1);
    chk(q0, 1'b1);
    r(8'h8C);
    chk(v, 8'hF0);
    // Gated count waits for the interrupt pin
    ws('{16'h8800, 16'h8909, 16'h8AFF, 16'h8CFF, 16'h8810});
    t(8);
    chk(q0, 1'b0);
    g0 <= 1'b1;
    t(6);
    chk(q0, 1'b1);
    // Split mode: high byte on timer 1 controls, low byte on timer 0
    ws('{16'h8800, 16'h8903, 16'h8CFE, 16'h8840});
    t(1);
    chk(q1, 1'b0);
    t(1);
    chk(q1, 1'b1);
    chk(q0, 1'b0);
    ws('{16'h8AFF, 16'h8850});
    t(1);
    chk(q0, 1'b1);
    chk(q1, 1'b0);
    // Timer 1 as baud source while split, then held in its mode 3
    ws('{16'h8800, 16'h8923, 16'h8DFF, 16'h8BFF});
    t(4);
    chk(txt, 1'b1);
    chk(rxt, 1'b1);
    chk(q1, 1'b0);
    w(16'h8933);
    t(3);
    chk(txt, 1'b0);
    // Timer 2 autoreload on overflow
    ws('{16'h8900, 16'hCAF0, 16'hCBFF, 16'hCCFE, 16'hCDFF, 16'hC804});
    t(1);
    chk(q2, 1'b0);
    t(1);
    chk(q2, 1'b1);
    chk(txt, 1'b0);
    r(8'hCD);
    chk(v, 8'hFF);
    // Edge ignored when disabled, captured when enabled
    ws('{16'hC800, 16'hCC34, 16'hCD12, 16'hC801});
    ex <= 1'b0;
    t(6);
    chk(q2, 1'b0);
    ex <= 1'b1;
    w(16'hC809);
    t(4);
    ex <= 1'b0;
    t(6);
    chk(q2, 1'b1);
    r(8'hCA);
    chk(v, 8'h34);
    r(8'hCB);
    chk(v, 8'h12);
    // Counter function counts only count pin falling edges
    ws('{16'hC800, 16'hCCFF, 16'hCDFF, 16'hC806});
    t(6);
    chk(q2, 1'b0);
    p2 <= 1'b0;
    t(6);
    chk(q2, 1'b1);
    // Baud use: reload every two cycles, one tick each, no flag
    ws('{16'hC800, 16'hCAFE, 16'hCBFF, 16'hCCFE, 16'hCDFF, 16'hC834});
    t(3);
    repeat (20) begin
      nr += int'(rxt);
      nt += int'(txt);
      t(1);
    end
    chk(8'(nr), 8'd10);
    chk(8'(nt), 8'd10);
    chk(q2, 1'b0);
    // Software set of timer 0 flag while stopped, then vector clear
    w(16'h8820);
    t(1);
    chk(q0, 1'b1);
    @(posedge i_clk);
    v0 <= 1'b1;
    @(posedge i_clk);
    v0 <= 1'b0;
    #1 chk(q0, 1'b0);
    report_and_stop();
  end
endmodule : mcu_timer_counters_0_1_2_tb
`default_nettype wire
